// *** verilog/gpio_pkg.sv ***
// shared constants for the fast gpio port: register map, field positions, reset values
package gpio_pkg;
  // ====================================================
  // bus shape
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // ====================================================
  // fast local copies: one block of words per port
  localparam int PORT_SEL_LSB = 5;
  localparam logic [4:0] OFS_DIR = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_PIN = 5'h08;
  localparam logic [4:0] OFS_SET = 5'h0c;
  localparam logic [4:0] OFS_CLR = 5'h10;
  localparam logic [ADDR_W-1:0] LOCAL_END = 10'h100;
  // ====================================================
  // edge interrupt block, first edge port then third edge port
  localparam logic [ADDR_W-1:0] EDGE_BASE = 10'h100;
  localparam logic [ADDR_W-1:0] EDGE_END = 10'h120;
  localparam int EDGE_HALF_BIT = 4;
  localparam logic [3:0] OFS_RISE_EN = 4'h0;
  localparam logic [3:0] OFS_FALL_EN = 4'h4;
  localparam logic [3:0] OFS_RISE_STAT = 4'h8;
  localparam logic [3:0] OFS_FALL_STAT = 4'hc;
  localparam int EDGE_PORT_A = 0;
  localparam int EDGE_PORT_B = 2;
  // ====================================================
  // interrupt status and mask
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 10'h140;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 10'h144;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_FIRST = 0;
  localparam int IRQ_THIRD = 1;
  localparam int IRQ_SHARED = 2;
  localparam logic [IRQ_BITS-1:0] IRQ_RST = 3'h0;
  // ====================================================
  // legacy copies of the first two ports
  localparam logic [ADDR_W-1:0] LEGACY_BASE = 10'h200;
  localparam logic [ADDR_W-1:0] LEGACY_END = 10'h220;
  localparam int LEGACY_SEL_BIT = 4;
  localparam logic [3:0] LG_PIN = 4'h0;
  localparam logic [3:0] LG_SET = 4'h4;
  localparam logic [3:0] LG_DIR = 4'h8;
  localparam logic [3:0] LG_CLR = 4'hc;
  // ====================================================
  // reset values
  localparam logic [DATA_W-1:0] DIR_RST = 32'h0;
  localparam logic [DATA_W-1:0] OUT_RST = 32'h0;
  localparam logic [DATA_W-1:0] MASK_RST = 32'h0;
endpackage : gpio_pkg

// *** verilog/gpio_edge_unit.sv ***
// per-pin rise/fall edge capture with sticky pending flags and wake request
module gpio_edge_unit #(
  parameter int N = 64
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] pins,
  input wire logic [N-1:0] next_rise_en,
  input wire logic [N-1:0] next_fall_en,
  input wire logic [N-1:0] rise_clr,
  input wire logic [N-1:0] fall_clr,
  output logic [N-1:0] rise_en,
  output logic [N-1:0] fall_en,
  output logic [N-1:0] rise_pend,
  output logic [N-1:0] fall_pend,
  output logic [1:0] hit,
  output logic wake
);
  typedef struct packed {
    logic armed;
    logic [N-1:0] prev;
    logic [N-1:0] rise_en;
    logic [N-1:0] fall_en;
    logic [N-1:0] rise_pend;
    logic [N-1:0] fall_pend;
    logic [1:0] hit;
    logic wake;
  } edge_s;
  edge_s s;
  edge_s n;
  logic [N-1:0] rise_hit;
  logic [N-1:0] fall_hit;

  // ====================================================
  // detection
  // runs without the clock enable so edges are still caught while the rest is frozen
  always_comb begin
    n = s;
    rise_hit = s.armed ? (pins & ~s.prev & s.rise_en) : '0;
    fall_hit = s.armed ? (~pins & s.prev & s.fall_en) : '0;
    n.armed = 1'b1;
    n.prev = pins;
    n.rise_en = next_rise_en;
    n.fall_en = next_fall_en;
    // a new edge wins over a clear in the same cycle
    n.rise_pend = (s.rise_pend & ~rise_clr) | rise_hit;
    n.fall_pend = (s.fall_pend & ~fall_clr) | fall_hit;
    n.hit[0] = |(rise_hit[N/2-1:0] | fall_hit[N/2-1:0]);
    n.hit[1] = |(rise_hit[N-1:N/2] | fall_hit[N-1:N/2]);
    n.wake = |(n.rise_pend | n.fall_pend);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rise_en = s.rise_en;
  assign fall_en = s.fall_en;
  assign rise_pend = s.rise_pend;
  assign fall_pend = s.fall_pend;
  assign hit = s.hit;
  assign wake = s.wake;

  a_edge_wakes: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s.armed && |(pins & ~s.prev & s.rise_en)) |=> (wake && |rise_pend))
    else $error("enabled rising edge did not set pending and wake");
  a_fall_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s.armed && |(~pins & s.prev & s.fall_en))
    |=> (fall_pend & $past(~pins & s.prev & s.fall_en)) == $past(~pins & s.prev & s.fall_en))
    else $error("enabled falling edge lost");
endmodule : gpio_edge_unit

// *** verilog/gpio_irq_ctrl.sv ***
// sticky interrupt status, write-one-to-clear, mask and one level interrupt
module gpio_irq_ctrl (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [gpio_pkg::IRQ_BITS-1:0] events,
  input wire logic [gpio_pkg::IRQ_BITS-1:0] stat_clr,
  input wire logic mask_we,
  input wire logic [gpio_pkg::IRQ_BITS-1:0] next_mask,
  output logic [gpio_pkg::IRQ_BITS-1:0] stat,
  output logic [gpio_pkg::IRQ_BITS-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [gpio_pkg::IRQ_BITS-1:0] stat;
    logic [gpio_pkg::IRQ_BITS-1:0] mask;
    logic irq;
  } irq_s;
  irq_s s;
  irq_s n;

  // ====================================================
  // status and request
  always_comb begin
    n = s;
    if (clk_en) begin
      n.stat = (s.stat & ~stat_clr) | events;
      if (mask_we) begin
        n.mask = next_mask;
      end
      n.irq = |(n.stat & n.mask);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{stat: gpio_pkg::IRQ_RST, mask: gpio_pkg::IRQ_RST, irq: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign stat = s.stat;
  assign mask = s.mask;
  assign irq = s.irq;

  a_shared_merged: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && events[gpio_pkg::IRQ_SHARED] && s.mask[gpio_pkg::IRQ_SHARED] && !mask_we)
    |=> irq)
    else $error("shared line request not merged onto interrupt");
  a_set_beats_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && |(events & stat_clr)) |=> ($past(events) & stat) == $past(events))
    else $error("event lost against a simultaneous clear");
endmodule : gpio_irq_ctrl

// *** verilog/gpio_fast_port.sv ***
// fast general purpose i/o ports with masked access, legacy copies and edge interrupts
// ====================================================
// Contract
// - unrouted pins are driven by gpio
// - per-pin direction changeable any time
// - separate set and clear registers
// - read output latch and live pins
// - mask register protects unselected port bits (the legacy copies ignore it)
// - byte and half-word lanes honoured everywhere (writes only; reads always return the whole word)
// - whole port written in one access
// - rise, fall or both edges raise interrupts
// - edge capture independent of clock gating
// - enabled pending edge requests wake
// - reset makes every pin an input
// - legacy copies of first two ports kept
// - edge requests merged with shared line
//
// The implementer's own choices: the address map and the strobed register port.
module gpio_fast_port #(
  parameter int NPORTS = 3
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [gpio_pkg::ADDR_W-1:0] addr,
  input wire logic [gpio_pkg::DATA_W-1:0] wr_data,
  input wire logic [gpio_pkg::BE_W-1:0] wr_be,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [gpio_pkg::DATA_W-1:0] rd_data,
  input wire logic [NPORTS*gpio_pkg::DATA_W-1:0] pad_in,
  output logic [NPORTS*gpio_pkg::DATA_W-1:0] pad_out,
  output logic [NPORTS*gpio_pkg::DATA_W-1:0] pad_oe,
  input wire logic [NPORTS*gpio_pkg::DATA_W-1:0] periph_sel,
  input wire logic [NPORTS*gpio_pkg::DATA_W-1:0] periph_out,
  input wire logic [NPORTS*gpio_pkg::DATA_W-1:0] periph_oe,
  input wire logic shared_external_irq_line,
  output logic irq,
  output logic wake
);
  localparam int W = gpio_pkg::DATA_W;
  localparam int EW = 2 * W;

  typedef struct packed {
    logic [NPORTS-1:0][W-1:0] dir;
    logic [NPORTS-1:0][W-1:0] out;
    logic [NPORTS-1:0][W-1:0] mask;
    logic [NPORTS*W-1:0] pad_out;
    logic [NPORTS*W-1:0] pad_oe;
    logic [W-1:0] rd_data;
  } port_s;
  port_s s;
  port_s n;

  // ====================================================
  // helpers
  // byte lanes of the bus; a half-word access is simply two lanes
  function automatic logic [W-1:0] lane_mask(input logic [gpio_pkg::BE_W-1:0] be);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < gpio_pkg::BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] d,
                                         input logic [W-1:0] sel);
    return (old & ~sel) | (d & sel);
  endfunction : merge

  // ====================================================
  // address decode
  logic [W-1:0] lm;
  logic [NPORTS-1:0][W-1:0] pins;
  logic is_local;
  logic is_edge;
  logic is_legacy;
  logic [4:0] port_idx;
  logic [4:0] local_ofs;
  logic edge_hi;
  logic [3:0] edge_ofs;
  logic lg_idx;
  logic [3:0] lg_ofs;

  assign pins = pad_in;
  assign lm = lane_mask(wr_be);
  assign port_idx = addr[gpio_pkg::ADDR_W-1:gpio_pkg::PORT_SEL_LSB];
  assign local_ofs = addr[gpio_pkg::PORT_SEL_LSB-1:0];
  assign is_local = (addr < gpio_pkg::LOCAL_END) && (int'(port_idx) < NPORTS);
  assign is_edge = (addr >= gpio_pkg::EDGE_BASE) && (addr < gpio_pkg::EDGE_END);
  assign is_legacy = (addr >= gpio_pkg::LEGACY_BASE) && (addr < gpio_pkg::LEGACY_END);
  assign edge_hi = addr[gpio_pkg::EDGE_HALF_BIT];
  assign edge_ofs = addr[3:0];
  assign lg_idx = addr[gpio_pkg::LEGACY_SEL_BIT];
  assign lg_ofs = addr[3:0];

  // ====================================================
  // edge unit and interrupt controller
  logic [EW-1:0] rise_en;
  logic [EW-1:0] fall_en;
  logic [EW-1:0] rise_pend;
  logic [EW-1:0] fall_pend;
  logic [EW-1:0] next_rise_en;
  logic [EW-1:0] next_fall_en;
  logic [EW-1:0] rise_clr;
  logic [EW-1:0] fall_clr;
  logic [1:0] hit;
  logic [gpio_pkg::IRQ_BITS-1:0] irq_stat;
  logic [gpio_pkg::IRQ_BITS-1:0] irq_mask;
  logic [gpio_pkg::IRQ_BITS-1:0] irq_clr;
  logic irq_mask_we;
  logic [EW-1:0] lm_wide;
  logic [EW-1:0] d_wide;

  assign lm_wide = edge_hi ? {lm, {W{1'b0}}} : {{W{1'b0}}, lm};
  assign d_wide = {wr_data, wr_data};

  function automatic logic [EW-1:0] merge2(input logic [EW-1:0] old, input logic [EW-1:0] d,
                                           input logic [EW-1:0] sel);
    return (old & ~sel) | (d & sel);
  endfunction : merge2

  // edge configuration writes are frozen with the bus; only the capture runs free
  always_comb begin
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    rise_clr = '0;
    fall_clr = '0;
    if (clk_en && wr_stb && is_edge) begin
      case (edge_ofs)
        gpio_pkg::OFS_RISE_EN: next_rise_en = merge2(rise_en, d_wide, lm_wide);
        gpio_pkg::OFS_FALL_EN: next_fall_en = merge2(fall_en, d_wide, lm_wide);
        gpio_pkg::OFS_RISE_STAT: rise_clr = d_wide & lm_wide;
        gpio_pkg::OFS_FALL_STAT: fall_clr = d_wide & lm_wide;
        default: ;
      endcase
    end
  end

  gpio_edge_unit #(.N(EW)) u_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pins({pins[gpio_pkg::EDGE_PORT_B], pins[gpio_pkg::EDGE_PORT_A]}),
    .next_rise_en(next_rise_en),
    .next_fall_en(next_fall_en),
    .rise_clr(rise_clr),
    .fall_clr(fall_clr),
    .rise_en(rise_en),
    .fall_en(fall_en),
    .rise_pend(rise_pend),
    .fall_pend(fall_pend),
    .hit(hit),
    .wake(wake)
  );

  // the mask is merged at bus width and cut to the few status bits on purpose
  logic [W-1:0] irq_mask_new;
  assign irq_mask_new = merge(W'(irq_mask), wr_data, lm);
  assign irq_mask_we = clk_en && wr_stb && (addr == gpio_pkg::IRQ_MASK_ADDR);
  assign irq_clr = (clk_en && wr_stb && (addr == gpio_pkg::IRQ_STAT_ADDR)) ?
                   (wr_data[gpio_pkg::IRQ_BITS-1:0] & lm[gpio_pkg::IRQ_BITS-1:0]) : '0;

  gpio_irq_ctrl u_irq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .events({shared_external_irq_line, hit[1], hit[0]}),
    .stat_clr(irq_clr),
    .mask_we(irq_mask_we),
    .next_mask(irq_mask_new[gpio_pkg::IRQ_BITS-1:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );

  // ====================================================
  // read mux
  logic [W-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    if (is_local) begin
      case (local_ofs)
        gpio_pkg::OFS_DIR: rd_val = s.dir[port_idx];
        gpio_pkg::OFS_MASK: rd_val = s.mask[port_idx];
        gpio_pkg::OFS_PIN: rd_val = pins[port_idx] & ~s.mask[port_idx];
        gpio_pkg::OFS_SET: rd_val = s.out[port_idx];
        default: rd_val = '0;
      endcase
    end else if (is_edge) begin
      case (edge_ofs)
        gpio_pkg::OFS_RISE_EN: rd_val = edge_hi ? rise_en[EW-1:W] : rise_en[W-1:0];
        gpio_pkg::OFS_FALL_EN: rd_val = edge_hi ? fall_en[EW-1:W] : fall_en[W-1:0];
        gpio_pkg::OFS_RISE_STAT: rd_val = edge_hi ? rise_pend[EW-1:W] : rise_pend[W-1:0];
        gpio_pkg::OFS_FALL_STAT: rd_val = edge_hi ? fall_pend[EW-1:W] : fall_pend[W-1:0];
        default: rd_val = '0;
      endcase
    end else if (addr == gpio_pkg::IRQ_STAT_ADDR) begin
      rd_val = W'(irq_stat);
    end else if (addr == gpio_pkg::IRQ_MASK_ADDR) begin
      rd_val = W'(irq_mask);
    end else if (is_legacy) begin
      case (lg_ofs)
        gpio_pkg::LG_PIN: rd_val = pins[lg_idx];
        gpio_pkg::LG_SET: rd_val = s.out[lg_idx];
        gpio_pkg::LG_DIR: rd_val = s.dir[lg_idx];
        default: rd_val = '0;
      endcase
    end
  end

  // ====================================================
  // register writes and pad drive
  always_comb begin
    n = s;
    if (clk_en) begin
      // read data stands one cycle, then falls back to zero
      n.rd_data = rd_stb ? (rd_val & lane_mask(wr_be | {gpio_pkg::BE_W{1'b1}})) : '0;
      if (wr_stb && is_local) begin
        case (local_ofs)
          gpio_pkg::OFS_DIR: n.dir[port_idx] = merge(s.dir[port_idx], wr_data, lm);
          gpio_pkg::OFS_MASK: n.mask[port_idx] = merge(s.mask[port_idx], wr_data, lm);
          gpio_pkg::OFS_PIN: // whole port in one write, masked bits kept
            n.out[port_idx] = merge(s.out[port_idx], wr_data, lm & ~s.mask[port_idx]);
          gpio_pkg::OFS_SET:
            n.out[port_idx] = s.out[port_idx] | (wr_data & lm & ~s.mask[port_idx]);
          gpio_pkg::OFS_CLR:
            n.out[port_idx] = s.out[port_idx] & ~(wr_data & lm & ~s.mask[port_idx]);
          default: ;
        endcase
      end else if (wr_stb && is_legacy) begin
        // legacy copies ignore the mask register, as older software expects
        case (lg_ofs)
          gpio_pkg::LG_PIN: n.out[lg_idx] = merge(s.out[lg_idx], wr_data, lm);
          gpio_pkg::LG_SET: n.out[lg_idx] = s.out[lg_idx] | (wr_data & lm);
          gpio_pkg::LG_DIR: n.dir[lg_idx] = merge(s.dir[lg_idx], wr_data, lm);
          gpio_pkg::LG_CLR: n.out[lg_idx] = s.out[lg_idx] & ~(wr_data & lm);
          default: ;
        endcase
      end
      // peripheral-routed pins bypass gpio, all others follow the latches
      n.pad_out = (periph_sel & periph_out) | (~periph_sel & s.out);
      n.pad_oe = (periph_sel & periph_oe) | (~periph_sel & s.dir);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s.dir <= {NPORTS{gpio_pkg::DIR_RST}};
      s.out <= {NPORTS{gpio_pkg::OUT_RST}};
      s.mask <= {NPORTS{gpio_pkg::MASK_RST}};
      s.pad_out <= '0;
      s.pad_oe <= '0;
      s.rd_data <= '0;
    end else begin
      s <= n;
    end
  end

  assign pad_out = s.pad_out;
  assign pad_oe = s.pad_oe;
  assign rd_data = s.rd_data;

  // ====================================================
  // checks
  // these look at the registered state one edge after the strobe or clk_en, except a_reset_inputs, which checks at the edge where reset falls
  a_reset_inputs: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> (pad_oe == '0 && s.dir == '0))
    else $error("pins not inputs after reset");
  a_set_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_stb && addr == gpio_pkg::OFS_SET)
    |=> s.out[0] == ($past(s.out[0]) | ($past(wr_data) & $past(lm) & ~$past(s.mask[0]))))
    else $error("set register wrong");
  a_clr_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_stb && addr == gpio_pkg::OFS_CLR)
    |=> (s.out[0] & $past(s.mask[0])) == ($past(s.out[0]) & $past(s.mask[0])))
    else $error("masked bits changed by clear");
  a_port_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_stb && addr == gpio_pkg::OFS_PIN && wr_be == 4'hf && s.mask[0] == '0)
    |=> s.out[0] == $past(wr_data))
    else $error("whole port write failed");
  a_latch_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && rd_stb && addr == gpio_pkg::OFS_SET && !wr_stb) |=> rd_data == $past(s.out[0]))
    else $error("latch readback wrong");
  a_byte_lane: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_stb && addr == gpio_pkg::OFS_DIR && wr_be == 4'h1)
    |=> s.dir[0][W-1:8] == $past(s.dir[0][W-1:8]))
    else $error("unaddressed lanes written");
  a_dir_to_pad: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en |=> pad_oe[W-1:0] ==
      $past((periph_sel[W-1:0] & periph_oe[W-1:0]) | (~periph_sel[W-1:0] & s.dir[0])))
    else $error("pad enable does not follow direction");
  a_legacy_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_stb && addr == (gpio_pkg::LEGACY_BASE + 10'(1 << gpio_pkg::LEGACY_SEL_BIT) +
     10'(gpio_pkg::LG_SET)) && wr_be == 4'hf)
    |=> (s.out[1] & $past(wr_data)) == $past(wr_data))
    else $error("legacy set on second port failed");
endmodule : gpio_fast_port

// *** dv/gpio_pins_model.sv ***
// board-side model of the pad wires: external drivers and pull-downs
module gpio_pins_model #(
  parameter int W = 96
) (
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_oe,
  output logic [W-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================
  // wire resolution
  // board pull-downs: a pin nobody drives reads low, never a stale level
  // the bench never lets the board drive a pin that the block drives
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val);
endmodule : gpio_pins_model

// *** dv/gpio_fast_port_tb.sv ***
// self-checking bench for the fast gpio port: register access, pads, edges, irq
module gpio_fast_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 3 * gpio_pkg::DATA_W;
  logic sys_clk, sys_rst, clk_en, wr_stb, rd_stb, shared_external_irq_line, irq, wake;
  logic [gpio_pkg::ADDR_W-1:0] addr;
  logic [gpio_pkg::DATA_W-1:0] wr_data, rd_data;
  logic [gpio_pkg::BE_W-1:0] wr_be;
  logic [PW-1:0] pad_in, pad_out, pad_oe, periph_sel, periph_out, periph_oe;
  logic [PW-1:0] ext_val, ext_oe;
  int errors, checked;
  // ====================================================
  // design and board
  gpio_fast_port #(.NPORTS(3)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr),
    .wr_data(wr_data), .wr_be(wr_be), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .periph_sel(periph_sel), .periph_out(periph_out), .periph_oe(periph_oe),
    .shared_external_irq_line(shared_external_irq_line), .irq(irq), .wake(wake)
  );
  gpio_pins_model #(.W(PW)) i_pins (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .ext_oe(ext_oe),
    .pad_in(pad_in)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ====================================================
  // tasks
  task summarize;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_be <= be;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask : rd
  // bounded wait for wake (which=0) or irq (which=1) to reach a level
  task wait_sig(input bit which, input logic lvl);
    int n;
    n = 0;
    // step past the edge so an output launched there has settled
    #1;
    while (((which ? irq : wake) !== lvl) && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({31'h0, which ? irq : wake}, {31'h0, lvl});
    if ((which ? irq : wake) !== lvl)
      summarize();
  endtask : wait_sig
  // ====================================================
  // main sequence
  initial begin
    {sys_rst, clk_en, wr_stb, rd_stb, shared_external_irq_line} = 5'h18;
    addr = 10'h0;
    wr_data = 32'h0;
    wr_be = 4'h0;
    {periph_sel, periph_out, periph_oe, ext_val, ext_oe} = '0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    check(pad_oe[31:0] | pad_oe[63:32] | pad_oe[95:64], 32'h0);
    rd(10'h000, 32'h0);
    rd(10'h044, 32'h0);
    // set, clear, lanes, whole port
    wr(10'h000, 32'h0000ffff, 4'hf);
    wr(10'h00c, 32'h000000f0, 4'hf);
    rd(10'h00c, 32'h000000f0);
    wr(10'h010, 32'h00000030, 4'hf);
    rd(10'h00c, 32'h000000c0);
    rd(10'h010, 32'h0);
    check(pad_oe[31:0], 32'h0000ffff);
    check(pad_out[31:0], 32'h000000c0);
    rd(10'h008, 32'h000000c0);
    wr(10'h008, 32'h12345678, 4'b0010);
    wr(10'h008, 32'hbeef0000, 4'b1100);
    rd(10'h00c, 32'hbeef56c0);
    wr(10'h008, 32'h0000a5a5, 4'hf);
    rd(10'h00c, 32'h0000a5a5);
    // mask protects bits 15:8
    wr(10'h004, 32'h0000ff00, 4'hf);
    wr(10'h00c, 32'h0000ffff, 4'hf);
    wr(10'h010, 32'h0000ffff, 4'hf);
    rd(10'h00c, 32'h0000a500);
    rd(10'h008, 32'h0);
    wr(10'h004, 32'h0, 4'hf);
    wr(10'h000, 32'h000000ff, 4'hf);
    wr(10'h000, 32'hffffffff, 4'h1);
    rd(10'h000, 32'h000000ff);
    rd(10'h008, 32'h00000000);
    // live pins and peripheral routing
    ext_oe[63:32] <= 32'hffffffff;
    ext_val[63:32] <= 32'hdeadbeef;
    {periph_sel[95], periph_out[95], periph_oe[95]} <= 3'h7;
    rd(10'h028, 32'hdeadbeef);
    check({29'h0, pad_oe[95], pad_out[95], pad_oe[94]}, 32'h6);
    check(pad_oe[31:0], 32'h000000ff);
    ext_oe[63:32] <= 32'h0;
    // legacy copies
    wr(10'h218, 32'h000000ff, 4'hf);
    wr(10'h214, 32'h0000000f, 4'hf);
    rd(10'h214, 32'h0000000f);
    rd(10'h020, 32'h000000ff);
    rd(10'h210, 32'h0000000f);
    wr(10'h21c, 32'h00000003, 4'hf);
    rd(10'h02c, 32'h0000000c);
    wr(10'h210, 32'h00000033, 4'h1);
    rd(10'h02c, 32'h00000033);
    wr(10'h004, 32'h000000ff, 4'hf);
    wr(10'h204, 32'h000000ff, 4'hf);
    rd(10'h00c, 32'h0000a5ff);
    wr(10'h004, 32'h0, 4'hf);
    // unmapped place
    wr(10'h300, 32'hffffffff, 4'hf);
    rd(10'h300, 32'h0);
    rd(10'h3fc, 32'h0);
    // rising edge on first edge port
    ext_oe[20] <= 1'b1;
    wr(10'h100, 32'h00100000, 4'hf);
    wr(10'h144, 32'h00000007, 4'hf);
    ext_val[20] <= 1'b1;
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b1, 1'b1);
    rd(10'h108, 32'h00100000);
    rd(10'h140, 32'h00000001);
    ext_val[20] <= 1'b0;
    rd(10'h10c, 32'h0);
    wr(10'h108, 32'h00100000, 4'hf);
    rd(10'h108, 32'h0);
    wait_sig(1'b0, 1'b0);
    check({31'h0, irq}, 32'h1);
    wr(10'h140, 32'h00000001, 4'hf);
    wait_sig(1'b1, 1'b0);
    // both edges on third edge port, then masked
    wr(10'h110, 32'h00000020, 4'hf);
    wr(10'h114, 32'h00000020, 4'hf);
    ext_oe[69] <= 1'b1;
    ext_val[69] <= 1'b1;
    wait_sig(1'b0, 1'b1);
    ext_val[69] <= 1'b0;
    rd(10'h118, 32'h00000020);
    rd(10'h11c, 32'h00000020);
    rd(10'h140, 32'h00000002);
    wr(10'h144, 32'h00000001, 4'hf);
    wait_sig(1'b1, 1'b0);
    wr(10'h118, 32'h00000020, 4'hf);
    wr(10'h11c, 32'h00000020, 4'hf);
    wr(10'h140, 32'h00000002, 4'hf);
    // shared line merged into the same request
    shared_external_irq_line <= 1'b1;
    repeat (2) @(posedge sys_clk);
    shared_external_irq_line <= 1'b0;
    rd(10'h140, 32'h00000004);
    check({31'h0, irq}, 32'h0);
    wr(10'h144, 32'h00000004, 4'hf);
    wait_sig(1'b1, 1'b1);
    wr(10'h140, 32'h00000004, 4'hf);
    wait_sig(1'b1, 1'b0);
    // line held high across a clear: the set wins
    shared_external_irq_line <= 1'b1;
    wait_sig(1'b1, 1'b1);
    wr(10'h140, 32'h00000004, 4'hf);
    rd(10'h140, 32'h00000004);
    shared_external_irq_line <= 1'b0;
    wr(10'h140, 32'h00000004, 4'hf);
    wait_sig(1'b1, 1'b0);
    // edge seen with the clock gated; bus refused meanwhile
    clk_en <= 1'b0;
    ext_val[20] <= 1'b1;
    wait_sig(1'b0, 1'b1);
    wr(10'h00c, 32'hffffffff, 4'hf);
    clk_en <= 1'b1;
    rd(10'h108, 32'h00100000);
    rd(10'h00c, 32'h0000a5ff);
    // reset in mid-run drops every driver
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    check(pad_oe[31:0] | pad_oe[63:32] | pad_oe[95:64], 32'h0);
    rd(10'h000, 32'h0);
    summarize();
  end
endmodule : gpio_fast_port_tb
